// File: shared/vfdcar_pkg.sv
// Constants and types for the display controller's configuration and annunciator registers.
// Assumes one 100 MHz system clock; the serial pins arrive from outside that clock's domain.
//
// Operation
// - Codes: dark, first half, second half, steady.
// - Byte holds four codes, first at D1:D0.
// - Config D0 low means shutdown, high runs.
// - Config D1 selects unlocked or locked.
// - D2 picks 1 s or 0.5 s blink.
// - D4 set clears blink counters at select release.
// - D5 set clears annunciator data at release.
// - D6 picks one or two digits per grid.
// - Config read D7 reports blink phase.
// - Word: R/W, 7-bit address, data, MSB first.
package vfdcar_pkg;

	// ----------------------------------------------------------------
	// Serial word layout
	// ----------------------------------------------------------------
	localparam int         WORD_BITS = 16;   // Bits per framed word
	localparam int         HEAD_BITS = 8;    // Flag plus address bits
	localparam logic [4:0] CNT_WORD  = 5'h10; // Bit count of a full word
	localparam logic [4:0] CNT_HEAD  = 5'h07; // Count before the last header bit
	localparam logic [4:0] CNT_MAX   = 5'h11; // Saturation of the bit counter

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [6:0] CFG_ADDR  = 7'h04; // Configuration register
	localparam logic [6:0] ANN_BASE  = 7'h20; // First annunciator byte
	localparam int         NUM_GRIDS = 48;    // Annunciator bytes, one per grid
	localparam logic [7:0] CFG_RESET = 8'h00; // Shut down, unlocked, slow, one digit

	// Configuration bit positions
	localparam int CFG_S = 0; // Run when set
	localparam int CFG_L = 1; // Lock
	localparam int CFG_B = 2; // Fast blink
	localparam int CFG_X = 3; // No function
	localparam int CFG_T = 4; // Blink counter sync
	localparam int CFG_R = 5; // Global clear
	localparam int CFG_M = 6; // Two digits per grid
	localparam int CFG_P = 7; // Blink phase, read only

	// ----------------------------------------------------------------
	// Annunciator codes
	// ----------------------------------------------------------------
	localparam logic [1:0] ANN_DARK   = 2'h0;
	localparam logic [1:0] ANN_FIRST  = 2'h1;
	localparam logic [1:0] ANN_SECOND = 2'h2;
	localparam logic [1:0] ANN_STEADY = 2'h3;
	localparam int         ANN_PER_BYTE = 4;

	// ----------------------------------------------------------------
	// Blink timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ         = 100_000_000;
	localparam int BLINK_SLOW_MS  = 1000; // Half period, slow
	localparam int BLINK_FAST_MS  = 500;  // Half period, fast
	localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * (CLK_HZ / 1000);
	localparam int BLINK_FAST_CYC = BLINK_FAST_MS * (CLK_HZ / 1000);
	localparam int BLINK_CNT_W    = 27;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       rw;   // High for a read
		logic [6:0] addr; // Command address
		logic [7:0] data; // Register data
	} vfdcar_word_type;

	typedef struct packed {
		logic m; // Two digits per grid
		logic r; // Global clear as written
		logic t; // Counter sync as written
		logic b; // Fast blink
		logic l; // Locked
		logic s; // Running
	} vfdcar_cfg_type;

endpackage

// File: hw/vfdcar_serial_rx.sv
// Serial slave for the display controller: frames 16-bit words and shifts read data out.
// Assumes select, clock and data come from pins and are sampled by the 100 MHz clock.
`timescale 1ns/1ns
module vfdcar_serial_rx
(
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       nrst_i,
	// Serial pins
	input  wire logic                       cs_n_i,
	input  wire logic                       sclk_i,
	input  wire logic                       din_i,
	output logic                            dout_o,
	// Register side
	input  wire logic [7:0]                 rd_data_i,
	output logic [6:0]                      rd_addr_o,
	output vfdcar_pkg::vfdcar_word_type     word_o,
	output logic                            word_valid_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [2:0]  cs_sync, next_cs_sync;     // Select synchroniser and edge stage
	logic [2:0]  sclk_sync, next_sclk_sync; // Clock synchroniser and edge stage
	logic [1:0]  din_sync, next_din_sync;   // Data synchroniser
	logic [15:0] shreg, next_shreg;         // Incoming word
	logic [4:0]  cnt, next_cnt;             // Rising clock edges in frame
	logic [7:0]  out_sh, next_out_sh;       // Outgoing read data
	logic        dout, next_dout;           // Output bit
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_rise;

	// Edges come from the second and third stages only
	assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
	assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
	assign cs_rise   = cs_sync[1] & ~cs_sync[2];

	// Address of a read, valid while the last header bit arrives
	assign rd_addr_o    = {shreg[5:0], din_sync[1]};
	assign word_o       = shreg;
	assign word_valid_o = cs_rise && (cnt == vfdcar_pkg::CNT_WORD);
	assign dout_o       = dout;

	// Next-state logic
	always_comb
	begin
		next_cs_sync   = {cs_sync[1:0], cs_n_i};
		next_sclk_sync = {sclk_sync[1:0], sclk_i};
		next_din_sync  = {din_sync[0], din_i};
		next_shreg     = shreg;
		next_cnt       = cnt;
		next_out_sh    = out_sh;
		next_dout      = dout;
		if (cs_sync[1])
		begin
			// Deselected: restart framing
			next_cnt  = 5'h00;
			next_dout = 1'b0;
		end
		else if (sclk_rise)
		begin
			// Shift in MSB first
			next_shreg = {shreg[14:0], din_sync[1]};
			if (cnt != vfdcar_pkg::CNT_MAX)
				next_cnt = cnt + 5'h01;
			if (cnt == vfdcar_pkg::CNT_HEAD && shreg[6])
				next_out_sh = rd_data_i;
		end
		else if (sclk_fall && cnt >= 5'h08 && cnt < vfdcar_pkg::CNT_WORD)
		begin
			// Present read data MSB first on falling edges
			next_dout   = out_sh[7];
			next_out_sh = {out_sh[6:0], 1'b0};
		end
	end

	// Registers
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cs_sync   <= 3'h7;
			sclk_sync <= 3'h0;
			din_sync  <= 2'h0;
			shreg     <= 16'h0000;
			cnt       <= 5'h00;
			out_sh    <= 8'h00;
			dout      <= 1'b0;
		end
		else
		begin
			cs_sync   <= next_cs_sync;
			sclk_sync <= next_sclk_sync;
			din_sync  <= next_din_sync;
			shreg     <= next_shreg;
			cnt       <= next_cnt;
			out_sh    <= next_out_sh;
			dout      <= next_dout;
		end
	end

endmodule // vfdcar_serial_rx

// File: hw/vfdcar_regs.sv
// Configuration and annunciator register bank of the display controller, with blink timing.
// Assumes a host on the four-wire serial pins; grid_sel_i comes from scan logic on mclk_i.
`timescale 1ns/1ns
module vfdcar_regs
#(
	parameter int BLINK_SLOW_CYC = vfdcar_pkg::BLINK_SLOW_CYC, // Slow half period
	parameter int BLINK_FAST_CYC = vfdcar_pkg::BLINK_FAST_CYC  // Fast half period
)
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	// Serial pins
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic        din_i,
	output logic             dout_o,
	// Scan side
	input  wire logic [5:0]  grid_sel_i,
	output logic [3:0]       ann_lit_o,
	// Mode outputs
	output logic             shutdown_o,
	output logic             config_locked_o,
	output logic             blink_fast_o,
	output logic             two_digit_o,
	output logic             blink_phase_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	// Number of annunciator bytes held here, one per grid
	localparam int NG = vfdcar_pkg::NUM_GRIDS;

	vfdcar_pkg::vfdcar_cfg_type  cfg, next_cfg;   // Configuration bits
	logic [7:0]                  ann [NG];        // Annunciator bytes
	logic [7:0]                  next_ann [NG];
	logic [vfdcar_pkg::BLINK_CNT_W-1:0] bcnt, next_bcnt; // Blink counter
	logic                        phase, next_phase; // Low in first half
	logic [3:0]                  lit, next_lit;   // Registered lit flags
	vfdcar_pkg::vfdcar_word_type word;            // Received word
	logic                        word_valid;      // Word committed
	logic [6:0]                  rd_addr;         // Address being read
	logic [7:0]                  rd_data;         // Read data to shift out
	logic [7:0]                  cfg_read;        // Configuration read value
	logic [5:0]                  rd_idx;          // Read annunciator index
	logic [5:0]                  wr_idx;          // Write annunciator index
	logic                        rd_ann_hit;
	logic                        wr_ann_hit;
	logic [vfdcar_pkg::BLINK_CNT_W-1:0] blink_lim; // Last count of half period

	// ----------------------------------------------------------------
	// Serial slave
	// ----------------------------------------------------------------
	vfdcar_serial_rx u_rx
	(
		.mclk_i       (mclk_i),
		.nrst_i       (nrst_i),
		.cs_n_i       (cs_n_i),
		.sclk_i       (sclk_i),
		.din_i        (din_i),
		.dout_o       (dout_o),
		.rd_data_i    (rd_data),
		.rd_addr_o    (rd_addr),
		.word_o       (word),
		.word_valid_o (word_valid)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Byte index of a read or a write inside the annunciator window
	assign rd_idx     = 6'(rd_addr - vfdcar_pkg::ANN_BASE);
	assign wr_idx     = 6'(word.addr - vfdcar_pkg::ANN_BASE);
	// Window hits; addresses past the last grid fall through
	assign rd_ann_hit = (rd_addr >= vfdcar_pkg::ANN_BASE)
		&& (rd_addr < 7'(vfdcar_pkg::ANN_BASE + 7'(NG)));
	assign wr_ann_hit = (word.addr >= vfdcar_pkg::ANN_BASE)
		&& (word.addr < 7'(vfdcar_pkg::ANN_BASE + 7'(NG)));

	// Configuration readback with live phase and a zero no-function bit
	always_comb
	begin
		cfg_read                   = 8'h00;
		cfg_read[vfdcar_pkg::CFG_P] = phase;
		cfg_read[vfdcar_pkg::CFG_M] = cfg.m;
		cfg_read[vfdcar_pkg::CFG_R] = cfg.r;
		cfg_read[vfdcar_pkg::CFG_T] = cfg.t;
		cfg_read[vfdcar_pkg::CFG_X] = 1'b0;
		cfg_read[vfdcar_pkg::CFG_B] = cfg.b;
		cfg_read[vfdcar_pkg::CFG_L] = cfg.l;
		cfg_read[vfdcar_pkg::CFG_S] = cfg.s;
	end

	// Read data selection; unmapped addresses read zero
	always_comb
	begin
		// Address is complete as the eighth link bit arrives
		if (rd_addr == vfdcar_pkg::CFG_ADDR)
			rd_data = cfg_read;
		else if (rd_ann_hit)
			rd_data = ann[rd_idx];
		else
			rd_data = 8'h00;
	end

	// ----------------------------------------------------------------
	// Register writes, clears and blink timing
	// ----------------------------------------------------------------
	// Terminal count of the half period for the selected rate
	assign blink_lim = cfg.b ? vfdcar_pkg::BLINK_CNT_W'(BLINK_FAST_CYC - 1)
		: vfdcar_pkg::BLINK_CNT_W'(BLINK_SLOW_CYC - 1);

	// Next values of configuration, annunciators and blink state
	always_comb
	begin
		next_cfg   = cfg;
		next_ann   = ann;
		next_bcnt  = bcnt;
		next_phase = phase;
		// Free-running half-period counter toggles the phase
		if (bcnt >= blink_lim)
		begin
			next_bcnt  = '0;
			next_phase = ~phase;
		end
		else
			next_bcnt = bcnt + 1'b1;
		// Writes take effect when select is released
		if (word_valid && !word.rw)
		begin
			if (word.addr == vfdcar_pkg::CFG_ADDR)
			begin
				// Lock bit always follows the write, so a locked bank can be opened
				next_cfg.l = word.data[vfdcar_pkg::CFG_L];
				if (!cfg.l)
				begin
					// Unlocked: all writable bits update, D3 dropped
					next_cfg.s = word.data[vfdcar_pkg::CFG_S];
					next_cfg.b = word.data[vfdcar_pkg::CFG_B];
					next_cfg.t = word.data[vfdcar_pkg::CFG_T];
					next_cfg.r = word.data[vfdcar_pkg::CFG_R];
					next_cfg.m = word.data[vfdcar_pkg::CFG_M];
				end
				// Sync restarts the blink period in its first half
				if (word.data[vfdcar_pkg::CFG_T])
				begin
					next_bcnt  = '0;
					next_phase = 1'b0;
				end
				// Global clear of annunciator data
				if (word.data[vfdcar_pkg::CFG_R])
				begin
					for (int i = 0; i < NG; i++)
						next_ann[i] = 8'h00;
				end
			end
			// Annunciator byte write; other addresses are ignored
			else if (wr_ann_hit)
				next_ann[wr_idx] = word.data;
		end
	end

	// Decode the selected grid's four codes into lit flags
	always_comb
	begin
		logic [7:0] sel_byte;
		logic [1:0] code;
		// Grids past the last byte decode as dark
		sel_byte = (grid_sel_i < 6'(NG)) ? ann[grid_sel_i] : 8'h00;
		code     = vfdcar_pkg::ANN_DARK;
		next_lit = 4'h0;
		// One two-bit code per annunciator, the first at the bottom
		for (int k = 0; k < vfdcar_pkg::ANN_PER_BYTE; k++)
		begin
			code = sel_byte[2*k +: 2];
			case (code)
				vfdcar_pkg::ANN_FIRST:  next_lit[k] = ~phase;
				vfdcar_pkg::ANN_SECOND: next_lit[k] = phase;
				vfdcar_pkg::ANN_STEADY: next_lit[k] = 1'b1;
				default:                next_lit[k] = 1'b0;
			endcase
		end
		// Nothing lights in shutdown
		if (!cfg.s)
			next_lit = 4'h0;
	end

	// Register all state
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			// Shut down, unlocked, all annunciators dark
			cfg   <= '0;
			bcnt  <= '0;
			phase <= 1'b0;
			lit   <= 4'h0;
			for (int i = 0; i < NG; i++)
				ann[i] <= 8'h00;
		end
		else
		begin
			// Take the next values on every edge
			cfg   <= next_cfg;
			bcnt  <= next_bcnt;
			phase <= next_phase;
			lit   <= next_lit;
			ann   <= next_ann;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Lit flags and modes come straight from flops
	assign ann_lit_o       = lit;
	assign shutdown_o      = ~cfg.s;
	assign config_locked_o = cfg.l;
	assign blink_fast_o    = cfg.b;
	assign two_digit_o     = cfg.m;
	assign blink_phase_o   = phase;

endmodule // vfdcar_regs

// File: verification/vfdcar_host.sv
// Host model: frames words on the four-wire serial port of the register bank.
// Assumes the bench calls xfer; link clock of 125 ns, held low between frames.
`timescale 1ns/1ns
module vfdcar_host
(
	// Clock and read data
	input  wire logic mclk_i,
	input  wire logic dout_i,
	// Serial pins
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      din_o
);
	// Idle pins at time zero
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o  = 1'b0;
	end

	// One frame of n bits, MSB first; read bits caught at rising edges
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge mclk_i);
		cs_n_o = 1'b0;
		// Offset keeps every link edge clear of the system clock's rising edge
		#2;
		for (int k = 0; k < n; k++)
		begin
			din_o = (k < 16) ? w[15 - k] : 1'b0;
			#62 sclk_o = 1'b1;
			if (k >= 8 && k < 16)
				rd[15 - k] = dout_i;
			#63 sclk_o = 1'b0;
		end
		#62 cs_n_o = 1'b1;
		din_o = ~din_o;
		#100;
	endtask
endmodule // vfdcar_host

// File: verification/vfdcar_regs_asserts.sv
// Checker: timing relations between the register bank's top ports.
// Assumes one clock domain, reset asynchronous and active low.
`timescale 1ns/1ns
module vfdcar_regs_asserts
#(
	parameter int BLINK_SLOW_CYC = 40, // Slow half period
	parameter int BLINK_FAST_CYC = 20  // Fast half period
)
(
	// Clock, reset and inputs
	input wire logic       mclk_i,
	input wire logic       nrst_i,
	input wire logic       cs_n_i,
	input wire logic       sclk_i,
	input wire logic [5:0] grid_sel_i,
	// Watched outputs
	input wire logic       dout_o,
	input wire logic [3:0] ann_lit_o,
	input wire logic       shutdown_o,
	input wire logic       config_locked_o,
	input wire logic       blink_fast_o,
	input wire logic       two_digit_o,
	input wire logic       blink_phase_o
);
	logic [31:0] gap;       // Cycles since the phase moved
	logic [31:0] next_gap;
	logic        ph_q;      // Phase one cycle back
	logic        next_ph_q;

	// Gap counter next state
	always_comb
	begin
		next_ph_q = blink_phase_o;
		next_gap  = (blink_phase_o != ph_q) ? 32'h0 : gap + 32'h1;
	end

	// Gap counter registers
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			gap  <= 32'h0;
			ph_q <= 1'b0;
		end
		else
		begin
			gap  <= next_gap;
			ph_q <= next_ph_q;
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_shut_dark;
		shutdown_o && $past(shutdown_o) |-> ann_lit_o == 4'h0;
	endproperty
	a_shut_dark: assert property (p_shut_dark) else $error("lit in shutdown");
	property p_cfg_quiet;
		(!cs_n_i) [*8] |-> $stable({shutdown_o, config_locked_o, blink_fast_o, two_digit_o});
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("mode moved in frame");
	property p_lock_hold;
		config_locked_o && $past(config_locked_o) |-> $stable({shutdown_o, blink_fast_o, two_digit_o});
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked mode moved");
	property p_phase_gap;
		blink_phase_o && !ph_q |-> gap >= BLINK_FAST_CYC - 1;
	endproperty
	a_phase_gap: assert property (p_phase_gap) else $error("phase too fast");
	property p_desel_dout;
		cs_n_i [*6] |-> !dout_o;
	endproperty
	a_desel_dout: assert property (p_desel_dout) else $error("dout while idle");
	property p_dout_hold;
		(sclk_i && !cs_n_i) [*6] |-> $stable(dout_o);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("dout moved high");
	property p_grid_range;
		grid_sel_i >= 6'h30 |=> ann_lit_o == 4'h0;
	endproperty
	a_grid_range: assert property (p_grid_range) else $error("lit past grids");
	property p_lit_quiet;
		($stable(grid_sel_i) && $stable(blink_phase_o) && cs_n_i) [*8] |-> $stable(ann_lit_o);
	endproperty
	a_lit_quiet: assert property (p_lit_quiet) else $error("lit moved alone");

	c_phase: cover property ($rose(blink_phase_o));
	c_lock: cover property (config_locked_o);
	c_dout: cover property (dout_o && !cs_n_i);
endmodule // vfdcar_regs_asserts

bind vfdcar_regs vfdcar_regs_asserts #(
	.BLINK_SLOW_CYC(BLINK_SLOW_CYC),
	.BLINK_FAST_CYC(BLINK_FAST_CYC)
) vfdcar_regs_asserts_i (
	.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
	.grid_sel_i(grid_sel_i), .dout_o(dout_o), .ann_lit_o(ann_lit_o),
	.shutdown_o(shutdown_o), .config_locked_o(config_locked_o),
	.blink_fast_o(blink_fast_o), .two_digit_o(two_digit_o),
	.blink_phase_o(blink_phase_o)
);

// File: verification/vfdcar_regs_tb.sv
// Bench: host model on the serial pins, bench drives reset and grid select.
// Assumes shortened blink half periods so phase timing fits the run.
`timescale 1ns/1ns
module vfdcar_regs_tb;
	localparam int SLOW = 4000; // Slow half period, cycles
	localparam int FAST = 2000; // Fast half period, cycles
	logic        mclk_i, nrst_i, cs_n_i, sclk_i, din_i, dout_o;
	logic [5:0]  grid_sel_i;
	logic [3:0]  ann_lit_o;
	logic        shutdown_o, config_locked_o, blink_fast_o, two_digit_o, blink_phase_o;
	logic [7:0]  exp_q[$]; // Expected read bytes
	logic [7:0]  got;      // Last read byte
	logic [31:0] seed;     // Random state
	int          n_errors;
	int          num_checks;
	event        rd_ev;

	vfdcar_regs #(.BLINK_SLOW_CYC(SLOW), .BLINK_FAST_CYC(FAST)) vfdcar_regs_i (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
		.din_i(din_i), .dout_o(dout_o), .grid_sel_i(grid_sel_i),
		.ann_lit_o(ann_lit_o), .shutdown_o(shutdown_o),
		.config_locked_o(config_locked_o), .blink_fast_o(blink_fast_o),
		.two_digit_o(two_digit_o), .blink_phase_o(blink_phase_o));
	vfdcar_host vfdcar_host_i (.mclk_i(mclk_i), .dout_i(dout_o),
		.cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));

	// System clock
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Lit flags expected from a byte and a phase
	function automatic logic [3:0] lit(input logic [7:0] b, input logic ph);
		logic [3:0] r;
		for (int k = 0; k < 4; k++)
			r[k] = (b[2*k +: 2] == 2'h3) || (b[2*k +: 2] == {ph, ~ph});
		return r;
	endfunction

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
		logic [7:0] r;
		vfdcar_host_i.xfer({1'b0, a, d}, n, r);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		exp_q.push_back(e);
		vfdcar_host_i.xfer({1'b1, a, 8'h00}, 16, r);
		got = r;
		->rd_ev;
	endtask

	task automatic pins(input logic [3:0] e);
		@(negedge mclk_i);
		chk({4'h0, e}, {4'h0, shutdown_o, config_locked_o, blink_fast_o, two_digit_o});
	endtask

	task automatic see(input logic [5:0] g, input logic [3:0] e);
		@(negedge mclk_i);
		grid_sel_i = g;
		repeat (3) @(negedge mclk_i);
		chk({4'h0, e}, {4'h0, ann_lit_o});
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Read results against the oldest note
	initial
	forever
	begin
		@(rd_ev);
		chk(exp_q.pop_front(), got);
	end

	// Watchdog: a clean run takes about 0.31 ms
	initial
	begin
		#800_000;
		n_errors++;
		finish_test();
	end

	initial
	begin
		logic [7:0] b;
		logic [5:0] g;
		logic [6:0] a;
		nrst_i = 1'b0;
		grid_sel_i = 6'h00;
		seed = 32'h39DFE659;
		repeat (12) @(negedge mclk_i);
		nrst_i = 1'b1;
		pins(4'h8);
		rd(7'h04, 8'h00);
		rd(7'h20, 8'h00);
		wr(7'h04, 8'h5D);
		pins(4'h3);
		rd(7'h04, 8'h55);
		repeat (2500) @(negedge mclk_i);
		rd(7'h04, 8'hD5);
		wr(7'h04, 8'h11);
		rd(7'h04, 8'h11);
		repeat (2500) @(negedge mclk_i);
		rd(7'h04, 8'h11);
		repeat (2000) @(negedge mclk_i);
		rd(7'h04, 8'h91);
		wr(7'h04, 8'h01);
		rd(7'h04, 8'h81);
		@(negedge mclk_i);
		chk(8'h01, {7'h00, blink_phase_o});
		$display("test modes done");
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			b = (i == 0) ? 8'hE4 : (i == 1) ? 8'h1B : seed[15:8];
			g = 6'(seed[7:0] % 8'h30);
			a = 7'h20 + {1'b0, g};
			wr(a, b);
			rd(a, b);
			wr(7'h04, 8'h11);
			see(g, lit(b, 1'b0));
			repeat (SLOW) @(negedge mclk_i);
			see(g, lit(b, 1'b1));
		end
		$display("test codes done");
		wr(a, ~b, 15);
		wr(a, ~b, 17);
		rd(a, b);
		wr(7'h10, 8'hA5);
		rd(7'h10, 8'h00);
		wr(7'h04, 8'h13);
		pins(4'h4);
		wr(7'h04, 8'h55);
		pins(4'h0);
		rd(7'h04, 8'h11);
		wr(a, 8'hFF);
		see(g, 4'hF);
		see(6'h32, 4'h0);
		wr(7'h04, 8'h10);
		pins(4'h8);
		see(g, 4'h0);
		wr(7'h04, 8'h31);
		rd(a, 8'h00);
		rd(7'h04, 8'h31);
		$display("test clear done");
		finish_test();
	end
endmodule // vfdcar_regs_tb
